// ===== src/amd_pkg.sv
package amd_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_ALARM_MASK  = 8'h18; // Alarm mask
    localparam logic [7:0] ADDR_HS_DIV      = 8'h19; // High-speed select
    localparam logic [7:0] ADDR_OUT1_UPPER  = 8'h1f; // Out1 bits 19:16
    localparam logic [7:0] ADDR_OUT1_MIDDLE = 8'h20; // Out1 bits 15:8
    localparam logic [7:0] ADDR_OUT1_LOWER  = 8'h21; // Out1 bits 7:0
    localparam logic [7:0] ADDR_OUT2_UPPER  = 8'h22; // Out2 bits 19:16
    localparam logic [7:0] ADDR_OUT2_MIDDLE = 8'h23; // Out2 bits 15:8
    localparam logic [7:0] ADDR_INT_CTRL    = 8'h30; // Pin enable, polarity
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h31; // Sticky events, W1C

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ALARM_MASK   = 8'h3f;
    localparam logic [7:0] RST_HS_DIV       = 8'h20;
    localparam logic [7:0] RST_OUT1_UPPER   = 8'h00;
    localparam logic [7:0] RST_OUT1_MIDDLE  = 8'h00;
    localparam logic [7:0] RST_OUT1_LOWER   = 8'h31;
    localparam logic [7:0] RST_OUT2_UPPER   = 8'h00;
    localparam logic [7:0] RST_INT_CTRL     = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ALARM_LOCK_LOSS_BIT = 0;   // Loss-of-lock mask/flag
    localparam int ALARM_IN1_FOS_BIT   = 1;   // First input offset
    localparam int ALARM_IN2_FOS_BIT   = 2;   // Second input offset
    localparam int ALARM_W             = 3;   // Alarm field width
    localparam int HS_DIV_LSB          = 5;   // Selector bits 7:5
    localparam int HS_DIV_W            = 3;
    localparam int UPPER_W             = 4;   // Divider bits 19:16
    localparam int INT_PIN_EN_BIT      = 0;   // Interrupt pin enable
    localparam int INT_POLARITY_BIT    = 1;   // Interrupt pin polarity

    // ------------------------------------------------------------------
    // Divider constants
    // ------------------------------------------------------------------
    localparam logic [3:0] HS_DIV_BASE = 4'h4;   // Code 000 divides by 4
    localparam int         LS_DIV_W    = 20;     // Low-speed divider width
    localparam int         NUM_OUTS    = 2;      // Output clocks 1 and 2

endpackage : amd_pkg

// ===== src/amd_regs.sv
// Summary of operation
// - Unmasked second-input offset flag raises interrupt
// - Unmasked first-input offset flag raises interrupt
// - Unmasked loss-of-lock flag raises interrupt
// - Mask writes never alter stored alarm flags
// - High-speed ratio equals selector code plus four
// - High-speed divider clocks both low-speed dividers
// - Out1 divider is 20 bits from three registers
// - Out2 divider upper and middle in registers
// - Interrupt pin driven only when enabled
// - Polarity bit sets interrupt pin active level
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns

module amd_regs #(
    parameter logic [7:0] OUT2_MIDDLE_RST = 8'h00  // Out2 middle reset
) (
    input  wire logic        ref_clk,                 // System clock
    input  wire logic        nrst,                    // Sync reset, low
    input  wire logic [7:0]  reg_addr,                // Register address
    input  wire logic [7:0]  reg_wdata,               // Write data
    input  wire logic        reg_wr,                  // Write strobe
    input  wire logic        reg_rd,                  // Read strobe
    output logic      [7:0]  reg_rdata,               // Read data, next cycle
    input  wire logic        in2_freq_offset_flag,    // Alarm flag input
    input  wire logic        in1_freq_offset_flag,    // Alarm flag input
    input  wire logic        lock_loss_flag,          // Alarm flag input
    input  wire logic [7:0]  out2_lowspeed_lower,     // Out2 bits 7:0
    output logic             int_pin_out,             // Interrupt pin level
    output logic             int_pin_oe,              // Interrupt pin drive
    output logic             irq,                     // Level interrupt
    output logic [2:0]       output_highspeed_divider,// Selector code
    output logic [19:0]      out1_lowspeed_divider,   // Out1 divider value
    output logic [19:0]      out2_lowspeed_divider,   // Out2 divider value
    output logic             output_clock_1,          // Out1 pulse
    output logic             output_clock_2           // Out2 pulse
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [2:0] alarm_mask;        // Per-alarm interrupt mask
    logic [2:0] hs_code;           // High-speed selector
    logic [3:0] out1_upper;        // Out1 bits 19:16
    logic [7:0] out1_middle;       // Out1 bits 15:8
    logic [7:0] out1_lower;        // Out1 bits 7:0
    logic [3:0] out2_upper;        // Out2 bits 19:16
    logic [7:0] out2_middle;       // Out2 bits 15:8
    logic       pin_enable;        // Interrupt pin enable
    logic       interrupt_polarity;// Interrupt pin active level
    logic [2:0] irq_status;        // Sticky alarm events
    logic [2:0] flag_prev;         // Last flag sample
    logic [2:0] alarm_flags;       // Flags gathered in field order
    logic [2:0] flag_rise;         // Rising edge of each flag
    logic       combined_status;   // OR of unmasked flags

    // ------------------------------------------------------------------
    // Divider datapath
    // ------------------------------------------------------------------
    logic [3:0]  hs_cnt;           // High-speed prescale count
    logic [3:0]  hs_ratio;         // Current high-speed ratio
    logic        hs_tick;          // One pulse per high-speed period
    logic [19:0] ls_val [amd_pkg::NUM_OUTS];  // Low-speed settings
    logic [19:0] ls_cnt [amd_pkg::NUM_OUTS];  // Low-speed counts
    logic [1:0]  ls_pulse;         // Registered output pulses

    // Address match helper, used by both write and read decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    // Flags in mask field order
    assign alarm_flags[amd_pkg::ALARM_LOCK_LOSS_BIT] = lock_loss_flag;
    assign alarm_flags[amd_pkg::ALARM_IN1_FOS_BIT]   = in1_freq_offset_flag;
    assign alarm_flags[amd_pkg::ALARM_IN2_FOS_BIT]   = in2_freq_offset_flag;

    // ------------------------------------------------------------------
    // Alarm mask register
    // ------------------------------------------------------------------
    // Only the mask bits are stored; flags live outside and stay intact
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            alarm_mask <= amd_pkg::RST_ALARM_MASK[2:0];
        end else if (reg_wr && hit(reg_addr, amd_pkg::ADDR_ALARM_MASK)) begin
            alarm_mask <= reg_wdata[2:0];
        end
    end

    // ------------------------------------------------------------------
    // High-speed divider selector
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            hs_code <= amd_pkg::RST_HS_DIV[7:5];
        end else if (reg_wr && hit(reg_addr, amd_pkg::ADDR_HS_DIV)) begin
            hs_code <= reg_wdata[7:5];
        end
    end

    // ------------------------------------------------------------------
    // Out1 low-speed divider bytes
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            out1_upper  <= amd_pkg::RST_OUT1_UPPER[3:0];
            out1_middle <= amd_pkg::RST_OUT1_MIDDLE;
            out1_lower  <= amd_pkg::RST_OUT1_LOWER;
        end else if (reg_wr) begin
            // Each byte lands in its own register
            if (hit(reg_addr, amd_pkg::ADDR_OUT1_UPPER)) begin
                out1_upper <= reg_wdata[3:0];
            end else if (hit(reg_addr, amd_pkg::ADDR_OUT1_MIDDLE)) begin
                out1_middle <= reg_wdata;
            end else if (hit(reg_addr, amd_pkg::ADDR_OUT1_LOWER)) begin
                out1_lower <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Out2 low-speed divider bytes
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            out2_upper  <= amd_pkg::RST_OUT2_UPPER[3:0];
            out2_middle <= OUT2_MIDDLE_RST;
        end else if (reg_wr) begin
            // Low byte is held outside this bank
            if (hit(reg_addr, amd_pkg::ADDR_OUT2_UPPER)) begin
                out2_upper <= reg_wdata[3:0];
            end else if (hit(reg_addr, amd_pkg::ADDR_OUT2_MIDDLE)) begin
                out2_middle <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt pin control
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pin_enable         <= amd_pkg::RST_INT_CTRL[0];
            interrupt_polarity <= amd_pkg::RST_INT_CTRL[1];
        end else if (reg_wr && hit(reg_addr, amd_pkg::ADDR_INT_CTRL)) begin
            pin_enable         <= reg_wdata[amd_pkg::INT_PIN_EN_BIT];
            interrupt_polarity <= reg_wdata[amd_pkg::INT_POLARITY_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Sticky event status
    // ------------------------------------------------------------------
    // Remember last flag sample for edge detection
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            flag_prev <= 3'h0;
        end else begin
            flag_prev <= alarm_flags;
        end
    end

    assign flag_rise = alarm_flags & ~flag_prev;

    // Write one clears; a new event in the same cycle wins
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            irq_status <= 3'h0;
        end else if (reg_wr && hit(reg_addr, amd_pkg::ADDR_IRQ_STATUS)) begin
            irq_status <= (irq_status & ~reg_wdata[2:0]) | flag_rise;
        end else begin
            irq_status <= irq_status | flag_rise;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt outputs
    // ------------------------------------------------------------------
    // Each flag feeds the pin only while its mask bit is zero
    always_comb begin
        combined_status =
            (alarm_flags[amd_pkg::ALARM_IN2_FOS_BIT]
                & ~alarm_mask[amd_pkg::ALARM_IN2_FOS_BIT])
            | (alarm_flags[amd_pkg::ALARM_IN1_FOS_BIT]
                & ~alarm_mask[amd_pkg::ALARM_IN1_FOS_BIT])
            | (alarm_flags[amd_pkg::ALARM_LOCK_LOSS_BIT]
                & ~alarm_mask[amd_pkg::ALARM_LOCK_LOSS_BIT]);
    end

    // Pin level follows polarity, driven only while enabled
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            int_pin_out <= 1'b0;
            int_pin_oe  <= 1'b0;
        end else begin
            int_pin_out <= interrupt_polarity ? combined_status
                                              : ~combined_status;
            int_pin_oe  <= pin_enable;
        end
    end

    // Level interrupt from unmasked sticky events
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & ~alarm_mask);
        end
    end

    // ------------------------------------------------------------------
    // High-speed divider
    // ------------------------------------------------------------------
    // Ratio is code plus four: 4 through 11
    assign hs_ratio = {1'b0, hs_code} + amd_pkg::HS_DIV_BASE;
    assign hs_tick  = (hs_cnt >= hs_ratio - 4'h1);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            hs_cnt <= 4'h0;
        end else if (hs_tick) begin
            hs_cnt <= 4'h0;
        end else begin
            hs_cnt <= hs_cnt + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Low-speed dividers, both fed by the high-speed tick
    // ------------------------------------------------------------------
    assign ls_val[0] = {out1_upper, out1_middle, out1_lower};
    assign ls_val[1] = {out2_upper, out2_middle, out2_lowspeed_lower};

    // Setting N divides by N+1; zero passes every tick. Each output is a
    // one-cycle pulse, whatever the parity of N; no duty cycle is shaped.
    generate
        for (genvar i = 0; i < amd_pkg::NUM_OUTS; i++) begin : g_ls
            always_ff @(posedge ref_clk) begin
                if (!nrst) begin
                    ls_cnt[i]   <= 20'h00000;
                    ls_pulse[i] <= 1'b0;
                end else if (hs_tick) begin
                    // Wrap when the setting is reached
                    if (ls_cnt[i] >= ls_val[i]) begin
                        ls_cnt[i]   <= 20'h00000;
                        ls_pulse[i] <= 1'b1;
                    end else begin
                        ls_cnt[i]   <= ls_cnt[i] + 20'h00001;
                        ls_pulse[i] <= 1'b0;
                    end
                end else begin
                    ls_pulse[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign output_clock_1 = ls_pulse[0];
    assign output_clock_2 = ls_pulse[1];

    // ------------------------------------------------------------------
    // Divider value outputs
    // ------------------------------------------------------------------
    assign output_highspeed_divider = hs_code;
    assign out1_lowspeed_divider    = ls_val[0];
    assign out2_lowspeed_divider    = ls_val[1];

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // Reserved bits return their reset values; unmapped reads give zero
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (!reg_rd) begin
            reg_rdata <= 8'h00;
        end else if (hit(reg_addr, amd_pkg::ADDR_ALARM_MASK)) begin
            reg_rdata <= {amd_pkg::RST_ALARM_MASK[7:3], alarm_mask};
        end else if (hit(reg_addr, amd_pkg::ADDR_HS_DIV)) begin
            reg_rdata <= {hs_code, amd_pkg::RST_HS_DIV[4:0]};
        end else if (hit(reg_addr, amd_pkg::ADDR_OUT1_UPPER)) begin
            reg_rdata <= {amd_pkg::RST_OUT1_UPPER[7:4], out1_upper};
        end else if (hit(reg_addr, amd_pkg::ADDR_OUT1_MIDDLE)) begin
            reg_rdata <= out1_middle;
        end else if (hit(reg_addr, amd_pkg::ADDR_OUT1_LOWER)) begin
            reg_rdata <= out1_lower;
        end else if (hit(reg_addr, amd_pkg::ADDR_OUT2_UPPER)) begin
            reg_rdata <= {amd_pkg::RST_OUT2_UPPER[7:4], out2_upper};
        end else if (hit(reg_addr, amd_pkg::ADDR_OUT2_MIDDLE)) begin
            reg_rdata <= out2_middle;
        end else if (hit(reg_addr, amd_pkg::ADDR_INT_CTRL)) begin
            reg_rdata <= {6'h00, interrupt_polarity, pin_enable};
        end else if (hit(reg_addr, amd_pkg::ADDR_IRQ_STATUS)) begin
            reg_rdata <= {5'h00, irq_status};
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // amd_regs

// ===== tb/amd_regs_checker.sv
`timescale 1ns/1ns

module amd_regs_checker (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        in2_freq_offset_flag,
    input wire logic        in1_freq_offset_flag,
    input wire logic        lock_loss_flag,
    input wire logic        int_pin_out,
    input wire logic        int_pin_oe,
    input wire logic [2:0]  output_highspeed_divider,
    input wire logic [19:0] out1_lowspeed_divider,
    input wire logic [19:0] out2_lowspeed_divider,
    input wire logic        output_clock_1
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic        dirty;    // Any write since last out1 pulse
    logic [31:0] since;    // Cycles since last out1 pulse
    logic [31:0] period;   // Expected out1 pulse spacing
    logic        any_flag; // Any alarm flag high

    assign any_flag = in2_freq_offset_flag | in1_freq_offset_flag
                      | lock_loss_flag;
    assign period = (32'(output_highspeed_divider) + 32'h4)
                    * (32'(out1_lowspeed_divider) + 32'h1);

    // Marks the period unknown after reset or any write
    always_ff @(posedge ref_clk) begin
        if (!nrst || reg_wr) begin
            dirty <= 1'b1;
        end else if (output_clock_1) begin
            dirty <= 1'b0;
        end
    end

    // Counts cycles between out1 pulses
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            since <= 32'h0;
        end else begin
            since <= output_clock_1 ? 32'h1 : since + 32'h1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_ctrl_write;
        reg_wr && reg_addr == amd_pkg::ADDR_INT_CTRL;
    endsequence
    sequence s_quiet;
        !any_flag;
    endsequence

    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    property p_hs_write;
        reg_wr && reg_addr == amd_pkg::ADDR_HS_DIV
        |=> output_highspeed_divider == $past(reg_wdata[7:5]);
    endproperty
    property p_out1_upper;
        reg_wr && reg_addr == amd_pkg::ADDR_OUT1_UPPER
        |=> out1_lowspeed_divider[19:16] == $past(reg_wdata[3:0]);
    endproperty
    property p_out1_lower;
        reg_wr && reg_addr == amd_pkg::ADDR_OUT1_LOWER
        |=> out1_lowspeed_divider[7:0] == $past(reg_wdata);
    endproperty
    property p_out2_middle;
        reg_wr && reg_addr == amd_pkg::ADDR_OUT2_MIDDLE
        |=> out2_lowspeed_divider[15:8] == $past(reg_wdata);
    endproperty
    property p_mask_read;
        reg_rd && reg_addr == amd_pkg::ADDR_ALARM_MASK
        |=> reg_rdata[7:3] == 5'h07;
    endproperty
    property p_hs_read;
        reg_rd && reg_addr == amd_pkg::ADDR_HS_DIV
        |=> reg_rdata == {$past(output_highspeed_divider), 5'h00};
    endproperty
    property p_pin_oe;
        s_ctrl_write |=> ##1 int_pin_oe == $past(reg_wdata[0], 2);
    endproperty
    property p_pin_pol;
        s_ctrl_write ##1 s_quiet |=> int_pin_out == !$past(reg_wdata[1], 2);
    endproperty
    property p_pulse_gap;
        output_clock_1 |=> !output_clock_1 [*3];
    endproperty
    property p_out1_period;
        output_clock_1 && !dirty |-> since == period;
    endproperty

    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read cycle");
    a_hs_write: assert property (p_hs_write)
        else $error("selector code not updated by write");
    a_out1_upper: assert property (p_out1_upper)
        else $error("out1 upper field not updated");
    a_out1_lower: assert property (p_out1_lower)
        else $error("out1 low byte not updated");
    a_out2_middle: assert property (p_out2_middle)
        else $error("out2 middle byte not updated");
    a_mask_read: assert property (p_mask_read)
        else $error("mask reserved bits wrong");
    a_hs_read: assert property (p_hs_read)
        else $error("selector readback wrong");
    a_pin_oe: assert property (p_pin_oe)
        else $error("pin enable does not follow control");
    a_pin_pol: assert property (p_pin_pol)
        else $error("idle pin level does not follow polarity");
    a_pulse_gap: assert property (p_pulse_gap)
        else $error("out1 pulses closer than four cycles");
    a_out1_period: assert property (p_out1_period)
        else $error("out1 pulse spacing wrong");

endmodule // amd_regs_checker

bind amd_regs amd_regs_checker amd_regs_checker_i (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .in2_freq_offset_flag(in2_freq_offset_flag),
    .in1_freq_offset_flag(in1_freq_offset_flag),
    .lock_loss_flag(lock_loss_flag), .int_pin_out(int_pin_out),
    .int_pin_oe(int_pin_oe),
    .output_highspeed_divider(output_highspeed_divider),
    .out1_lowspeed_divider(out1_lowspeed_divider),
    .out2_lowspeed_divider(out2_lowspeed_divider),
    .output_clock_1(output_clock_1)
);

// ===== tb/tb_amd_regs.sv
`timescale 1ns/1ns

module tb_amd_regs;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        ref_clk;
    logic        nrst;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [2:0]  flags;       // In2, in1, lock loss
    logic [7:0]  out2_lower;  // Out2 low byte input
    logic        int_pin_out;
    logic        int_pin_oe;
    logic        irq;
    logic [2:0]  hs_code;
    logic [19:0] out1_div;
    logic [19:0] out2_div;
    logic        clk1;
    logic        clk2;
    logic [7:0]  rd_val;      // Last read result
    int          miscompares = 0;
    int          n_checks = 0;
    int          cycles = 0;  // Timeout counter

    amd_regs amd_regs_i (
        .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .in2_freq_offset_flag(flags[2]),
        .in1_freq_offset_flag(flags[1]), .lock_loss_flag(flags[0]),
        .out2_lowspeed_lower(out2_lower), .int_pin_out(int_pin_out),
        .int_pin_oe(int_pin_oe), .irq(irq),
        .output_highspeed_divider(hs_code),
        .out1_lowspeed_divider(out1_div), .out2_lowspeed_divider(out2_div),
        .output_clock_1(clk1), .output_clock_2(clk2)
    );

    // Free-running 25 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp,
                       input string what);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e,
                        input string w);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 rd_val = reg_rdata;
        chk(rd_val, e, w);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rchk(8'h18, 8'h3f, "mask reset");
        rchk(8'h19, 8'h20, "hs reset");
        rchk(8'h1f, 8'h00, "out1 upper reset");
        rchk(8'h20, 8'h00, "out1 middle reset");
        rchk(8'h21, 8'h31, "out1 lower reset");
        rchk(8'h22, 8'h00, "out2 upper reset");
        chk(out1_div, 20'h00031, "out1 value");
        chk(hs_code, 3'h1, "hs code");
        $display("t_reset done");
    endtask

    task automatic t_regs();
        wr(8'h18, 8'hf8);
        rchk(8'h18, 8'h38, "mask reserved");
        for (int i = 0; i < 8; i++) begin
            wr(8'h19, {i[2:0], 5'h1f});
            rchk(8'h19, {i[2:0], 5'h00}, "hs readback");
            chk(hs_code, i[2:0], "hs code");
        end
        wr(8'h1f, 8'hff);
        wr(8'h20, 8'ha5);
        wr(8'h21, 8'h3b);
        rchk(8'h1f, 8'h0f, "out1 upper");
        rchk(8'h20, 8'ha5, "out1 mid");
        chk(out1_div, 20'hfa53b, "out1 value");
        wr(8'h22, 8'hf7);
        wr(8'h23, 8'h5c);
        out2_lower <= 8'h09;
        rchk(8'h22, 8'h07, "out2 upper");
        rchk(8'h23, 8'h5c, "out2 mid");
        chk(out2_div, 20'h75c09, "out2 value");
        wr(8'h05, 8'hff);
        rchk(8'h05, 8'h00, "unmapped");
        $display("t_regs done");
    endtask

    task automatic t_irq();
        logic [2:0] b;
        for (int i = 0; i < 3; i++) begin
            b = 3'b001 << i;
            wr(8'h18, 8'h07);
            wr(8'h31, 8'h07);
            @(posedge ref_clk);
            flags <= b;
            cyc(3);
            @(posedge ref_clk);
            flags <= 3'b000;
            cyc(3);
            chk(irq, 1'b0, "masked irq");
            wr(8'h18, {5'h00, ~b});
            cyc(3);
            chk(irq, 1'b1, "unmasked irq");
            rchk(8'h31, {5'h00, b}, "status kept");
            wr(8'h31, {5'h00, b});
            cyc(3);
            chk(irq, 1'b0, "irq cleared");
        end
        wr(8'h18, 8'h00);
        wr(8'h30, 8'h03);
        @(posedge ref_clk);
        flags <= 3'b010;
        cyc(3);
        chk(int_pin_oe, 1'b1, "pin enabled");
        chk(int_pin_out, 1'b1, "pin high active");
        wr(8'h30, 8'h01);
        cyc(3);
        chk(int_pin_out, 1'b0, "pin low active");
        wr(8'h18, 8'h02);
        cyc(3);
        chk(int_pin_out, 1'b1, "masked pin idle");
        wr(8'h30, 8'h00);
        cyc(3);
        chk(int_pin_oe, 1'b0, "pin disabled");
        @(posedge ref_clk);
        flags <= 3'b000;
        wr(8'h31, 8'h07);
        $display("t_irq done");
    endtask

    // Cycles between two pulses of one output
    task automatic meas(input logic sel, output int p);
        int n;
        n = 0;
        cyc(1);
        while ((sel ? clk2 : clk1) !== 1'b1 && n < 1000) begin
            cyc(1);
            n++;
        end
        cyc(1);
        p = 1;
        while ((sel ? clk2 : clk1) !== 1'b1 && p < 1000) begin
            cyc(1);
            p++;
        end
    endtask

    task automatic t_div();
        logic [2:0] code [3] = '{3'h0, 3'h7, 3'h3};
        logic [7:0] n1 [3] = '{8'h00, 8'h01, 8'h03};
        logic [7:0] n2 [3] = '{8'h00, 8'h03, 8'h01};
        int p;
        wr(8'h1f, 8'h00);
        wr(8'h20, 8'h00);
        wr(8'h22, 8'h00);
        wr(8'h23, 8'h00);
        for (int k = 0; k < 3; k++) begin
            wr(8'h19, {code[k], 5'h00});
            wr(8'h21, n1[k]);
            out2_lower <= n2[k];
            meas(1'b0, p);
            chk(20'(p), 20'((code[k] + 4) * (n1[k] + 1)), "out1");
            meas(1'b1, p);
            chk(20'(p), 20'((code[k] + 4) * (n2[k] + 1)), "out2");
        end
        $display("t_div done");
    endtask

    // ------------------------------------------------------------------
    // Main sequence and verdict
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        nrst       = 1'b0;
        reg_addr   = 8'h00;
        reg_wdata  = 8'h00;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        flags      = 3'b000;
        out2_lower = 8'h00;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset();
        t_regs();
        t_irq();
        t_div();
        final_report();
    end

endmodule // tb_amd_regs
